// ==== logic/serial_pkg.sv ====
// constants and carriers shared by the serial flag and clock pin block
package serial_pkg;
  localparam int CLK_HZ = 125_000_000;
  // register offsets
  localparam logic [3:0] OFS_MODE    = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h1;
  localparam logic [3:0] OFS_STATUS  = 4'h2;
  localparam logic [3:0] OFS_TXHOLD  = 4'h3;
  localparam logic [3:0] OFS_RXHOLD  = 4'h4;
  localparam logic [3:0] OFS_BAUD    = 4'h5;
  localparam logic [3:0] OFS_SYSCTL  = 4'h6;
  // mode register fields
  localparam int MODE_SYNC_BIT = 7;
  // control register fields
  localparam int CTL_TXEN_BIT  = 5;
  localparam int CTL_RXEN_BIT  = 4;
  localparam int CTL_CKHI_BIT  = 1;
  localparam int CTL_CKLO_BIT  = 0;
  // status register fields
  localparam int ST_TXE_BIT    = 7;
  localparam int ST_RXF_BIT    = 6;
  localparam int ST_OVR_BIT    = 5;
  localparam int ST_FRM_BIT    = 4;
  localparam int ST_PAR_BIT    = 3;
  localparam int ST_TXD_BIT    = 2;
  // system control fields
  localparam int SYS_SUBCLK_BIT = 1;
  localparam int SYS_SUBMODE_BIT = 0;
  // reset values
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] CTL_RST    = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  // timing
  localparam int OVERSAMPLE   = 16;
  localparam int MID_SAMPLE   = 8;
  localparam int FRAME_BITS   = 8;
  localparam int LOWPULSE_NS  = 8;
  localparam int LOWPULSE_CYC = (LOWPULSE_NS * CLK_HZ / 1_000_000 + 999) / 1000 < 1 ? 1 :
                                (LOWPULSE_NS * CLK_HZ / 1_000_000 + 999) / 1000;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic txd;
    logic sck_o;
    logic sck_oe;
  } pins_s;
endpackage

// ==== logic/rate_div.sv ====
// divider making the sixteen-times base clock enable
`timescale 1ns/100ps
`default_nettype none
module rate_div #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // control
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] divisor,
  // enable out
  output logic                  tick
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } st_s;
  st_s st_q;
  st_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= divisor) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule
`default_nettype wire

// ==== logic/serial_unit.sv ====
// serial unit: status flags, holding registers, shifters and clock pin control
// Overview of operation
// - clock pin leaving clock-output duty because sync mode is cleared is driven low for one short pulse; setting the clock-high bit first gives none.
// - writing the transmit holding register clears the transmit-empty flag.
// - moving holding byte into the shifter sets the transmit-empty flag.
// - holding writes always accepted; an unmoved byte is overwritten.
// - frame end with receive-full still set raises overrun.
// - reading the receive holding register clears the receive-full flag.
// - a read coinciding with frame end may return the new frame.
// - in subclock modes the unit runs only with division select set.
// - last bit out with transmit-empty set sets transmit-done.
// - asynchronous bits use a sixteen-times base clock, sampled mid-bit.
// - synchronous transmit waits while any receive error flag is set.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module serial_unit
  import serial_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // register port
  input  wire serial_pkg::bus_req_s bus,
  output logic [7:0]                rdata,
  // serial pins
  input  wire logic                 rxd,
  input  wire logic                 sck_i,
  output serial_pkg::pins_s         pins
);
  import serial_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctl;
    logic [7:0] baud;
    logic [7:0] sys;
    logic [7:0] tx_hold;
    logic [7:0] tx_shift;
    logic [7:0] rx_hold;
    logic [7:0] rx_shift;
    logic       txe;
    logic       rxf;
    logic       ovr;
    logic       frm;
    logic       txd_flag;
    tx_e        tx_st;
    rx_e        rx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_bit;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic       sck_was_clk;
    logic       low_pulse;
    logic       sck_prev;
    logic [7:0] rdata;
    pins_s      pins;
  } st_s;

  st_s  st_q;
  st_s  st_d;
  logic tick;
  logic sync_mode;
  logic clk_out;
  logic allowed;

  assign sync_mode = st_q.mode[MODE_SYNC_BIT];
  assign clk_out   = sync_mode && !st_q.ctl[CTL_CKHI_BIT];
  // unit halted in subclock mode unless the division select is set
  assign allowed   = !st_q.sys[SYS_SUBMODE_BIT] || st_q.sys[SYS_SUBCLK_BIT];

  rate_div #(.WIDTH(DIV_W)) u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (allowed),
    .divisor  (st_q.baud),
    .tick     (tick)
  );

  function automatic logic [7:0] status_byte(input st_s s);
    status_byte = 8'h00;
    status_byte[ST_TXE_BIT] = s.txe;
    status_byte[ST_RXF_BIT] = s.rxf;
    status_byte[ST_OVR_BIT] = s.ovr;
    status_byte[ST_FRM_BIT] = s.frm;
    status_byte[ST_TXD_BIT] = s.txd_flag;
  endfunction

  always_comb begin
    logic wr_tx;
    logic rd_rx;
    logic frame_done;
    logic sck_rise;
    logic sck_fall;
    logic bit_step;
    wr_tx = 1'b0;
    rd_rx = 1'b0;
    frame_done = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    bit_step = 1'b0;
    st_d = st_q;
    st_d.rdata = 8'h00;
    wr_tx = bus.wr && bus.addr == OFS_TXHOLD;
    rd_rx = bus.rd && bus.addr == OFS_RXHOLD;
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_MODE:    st_d.mode = bus.wdata;
        OFS_CONTROL: st_d.ctl = bus.wdata;
        OFS_BAUD:    st_d.baud = bus.wdata;
        OFS_SYSCTL:  st_d.sys = bus.wdata;
        OFS_STATUS: begin
          // software clears error flags by writing zero
          if (!bus.wdata[ST_OVR_BIT]) st_d.ovr = 1'b0;
          if (!bus.wdata[ST_FRM_BIT]) st_d.frm = 1'b0;
          if (!bus.wdata[ST_TXD_BIT]) st_d.txd_flag = 1'b0;
        end
        default: ;
      endcase
    end
    if (wr_tx) begin
      st_d.tx_hold = bus.wdata;
      st_d.txe = 1'b0;
      st_d.txd_flag = 1'b0;
    end
    // reads return data the following cycle; rx read uses updated hold
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_MODE:    st_d.rdata = st_q.mode;
        OFS_CONTROL: st_d.rdata = st_q.ctl;
        OFS_STATUS:  st_d.rdata = status_byte(st_q);
        OFS_TXHOLD:  st_d.rdata = st_q.tx_hold;
        OFS_RXHOLD:  st_d.rdata = st_q.rx_hold;
        OFS_BAUD:    st_d.rdata = st_q.baud;
        OFS_SYSCTL:  st_d.rdata = st_q.sys;
        default:     st_d.rdata = 8'h00;
      endcase
    end
    if (rd_rx) begin
      st_d.rxf = 1'b0;
    end
    // synchronous clock edges
    st_d.sck_prev = clk_out ? st_q.pins.sck_o : sck_i;
    sck_rise = !st_q.sck_prev && (clk_out ? st_q.pins.sck_o : sck_i);
    sck_fall = st_q.sck_prev && !(clk_out ? st_q.pins.sck_o : sck_i);
    // transmitter
    if (!st_q.ctl[CTL_TXEN_BIT] || !allowed) begin
      st_d.tx_st = TX_IDLE;
      st_d.pins.txd = 1'b1;
      st_d.tx_sub = 4'h0;
    end else begin
      bit_step = sync_mode ? sck_fall : (tick && st_q.tx_sub == 4'(OVERSAMPLE - 1));
      if (tick && !sync_mode) st_d.tx_sub = st_q.tx_sub + 4'h1;
      unique case (st_q.tx_st)
        TX_IDLE: begin
          if (!st_q.txe && !(sync_mode && (st_q.ovr || st_q.frm))) begin
            st_d.tx_shift = st_q.tx_hold;
            // a holding write in the same cycle keeps the flag clear
            if (!wr_tx) st_d.txe = 1'b1;
            st_d.tx_bit = 3'h0;
            st_d.tx_sub = 4'h0;
            st_d.tx_st = sync_mode ? TX_DATA : TX_START;
            if (!sync_mode) st_d.pins.txd = 1'b0;
            else st_d.pins.txd = st_q.tx_hold[0];
          end
        end
        TX_START: if (bit_step) begin
          st_d.pins.txd = st_q.tx_shift[0];
          st_d.tx_st = TX_DATA;
        end
        TX_DATA: if (bit_step) begin
          st_d.tx_shift = {1'b0, st_q.tx_shift[7:1]};
          st_d.tx_bit = st_q.tx_bit + 3'h1;
          st_d.pins.txd = st_q.tx_shift[1];
          if (st_q.tx_bit == 3'(FRAME_BITS - 1)) begin
            st_d.pins.txd = 1'b1;
            st_d.tx_st = sync_mode ? TX_IDLE : TX_STOP;
            if (sync_mode && st_d.txe && !wr_tx) st_d.txd_flag = 1'b1;
          end
        end
        TX_STOP: if (bit_step) begin
          st_d.tx_st = TX_IDLE;
          if (st_d.txe && !wr_tx) st_d.txd_flag = 1'b1;
        end
      endcase
    end
    // receiver
    if (!st_q.ctl[CTL_RXEN_BIT] || !allowed) begin
      st_d.rx_st = RX_IDLE;
    end else begin
      if (tick && !sync_mode) st_d.rx_sub = st_q.rx_sub + 4'h1;
      unique case (st_q.rx_st)
        RX_IDLE: begin
          if (sync_mode ? sck_rise : !rxd) begin
            st_d.rx_sub = 4'h0;
            st_d.rx_bit = 3'h0;
            st_d.rx_st = sync_mode ? RX_DATA : RX_START;
            if (sync_mode) st_d.rx_shift = {rxd, st_q.rx_shift[7:1]};
          end
        end
        RX_START: if (tick && st_q.rx_sub == 4'(MID_SAMPLE - 1)) begin
          st_d.rx_sub = 4'h0;
          st_d.rx_st = rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (sync_mode ? sck_rise : (tick && st_q.rx_sub == 4'(OVERSAMPLE - 1))) begin
            st_d.rx_shift = {rxd, st_q.rx_shift[7:1]};
            st_d.rx_bit = st_q.rx_bit + 3'h1;
          end
          // sync bit 0 came in on the starting edge
          if (sync_mode ? (st_q.rx_bit == 3'(FRAME_BITS - 2) && sck_rise)
                        : (st_q.rx_bit == 3'(FRAME_BITS - 1) && tick
                           && st_q.rx_sub == 4'(OVERSAMPLE - 1))) begin
            st_d.rx_st = RX_STOP;
          end
        end
        RX_STOP: if (sync_mode || (tick && st_q.rx_sub == 4'(OVERSAMPLE - 1))) begin
          frame_done = 1'b1;
          st_d.rx_st = RX_IDLE;
          if (!sync_mode && !rxd) st_d.frm = 1'b1;
        end
      endcase
    end
    if (frame_done) begin
      if (st_q.rxf) begin
        st_d.ovr = 1'b1;
      end else begin
        st_d.rx_hold = st_q.rx_shift;
        st_d.rxf = 1'b1;
        if (rd_rx) st_d.rdata = st_q.rx_shift;
      end
    end
    // clock pin: in sync mode with the clock-high bit clear the output clock toggles per base tick while transmitting and idles high otherwise
    st_d.sck_was_clk = clk_out;
    st_d.low_pulse = 1'b0;
    if (clk_out) begin
      st_d.pins.sck_oe = 1'b1;
      if (tick && st_q.tx_st != TX_IDLE) st_d.pins.sck_o = !st_q.pins.sck_o;
      else if (st_q.tx_st == TX_IDLE) st_d.pins.sck_o = 1'b1;
    end else if (st_q.sck_was_clk && !sync_mode) begin
      st_d.low_pulse = 1'b1;
      st_d.pins.sck_oe = 1'b1;
      st_d.pins.sck_o = 1'b0;
    end else begin
      st_d.pins.sck_oe = 1'b0;
      st_d.pins.sck_o = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.mode <= MODE_RST;
      st_q.ctl <= CTL_RST;
      st_q.baud <= BAUD_RST;
      st_q.sys <= SYSCTL_RST;
      st_q.txe <= 1'b1;
      st_q.txd_flag <= 1'b1;
      st_q.tx_st <= TX_IDLE;
      st_q.rx_st <= RX_IDLE;
      // idle clock level, so no false edge follows reset
      st_q.sck_prev <= 1'b1;
      st_q.pins <= '{txd: 1'b1, sck_o: 1'b1, sck_oe: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign pins  = st_q.pins;

  a_txe_clear: assert property (@(posedge core_clk) disable iff (srst)
    bus.wr && bus.addr == OFS_TXHOLD |=> !st_q.txe)
    else $error("transmit-empty not cleared by holding write");
  a_rxf_clear: assert property (@(posedge core_clk) disable iff (srst)
    bus.rd && bus.addr == OFS_RXHOLD && st_q.rx_st != RX_STOP |=> !st_q.rxf)
    else $error("receive-full not cleared by read");
  a_overrun_set: assert property (@(posedge core_clk) disable iff (srst)
    st_q.rx_st == RX_STOP && st_d.rx_st == RX_IDLE && st_q.ctl[CTL_RXEN_BIT] && allowed
    && st_q.rxf |=> st_q.ovr)
    else $error("frame end with receive-full set did not raise overrun");
  a_low_pulse: assert property (@(posedge core_clk) disable iff (srst)
    st_q.low_pulse |-> pins.sck_oe && !pins.sck_o ##1 !st_q.low_pulse)
    else $error("clock pin low pulse wrong");
  a_sync_hold: assert property (@(posedge core_clk) disable iff (srst)
    sync_mode && st_q.ovr && st_q.tx_st == TX_IDLE |=> st_q.tx_st == TX_IDLE)
    else $error("transmit started with error flag set");
  a_sub_halt: assert property (@(posedge core_clk) disable iff (srst)
    !allowed |=> st_q.tx_st == TX_IDLE && st_q.rx_st == RX_IDLE)
    else $error("unit ran in subclock without division select");
  a_txe_load: assert property (@(posedge core_clk) disable iff (srst)
    st_q.tx_st == TX_IDLE && st_d.tx_st != TX_IDLE && !(bus.wr && bus.addr == OFS_TXHOLD)
    |=> st_q.txe && st_q.tx_shift == $past(st_q.tx_hold))
    else $error("shifter load did not set transmit-empty");
  a_rxf_prio: assert property (@(posedge core_clk) disable iff (srst)
    st_q.rx_st == RX_STOP && st_d.rx_st == RX_IDLE && st_q.ctl[CTL_RXEN_BIT] && allowed
    && !st_q.rxf |=> st_q.rxf)
    else $error("frame completion lost receive-full");
  c_tx_frame: cover property (@(posedge core_clk) st_q.tx_st == TX_STOP);
  c_rx_frame: cover property (@(posedge core_clk) st_q.rx_st == RX_STOP ##1 st_q.rxf);
  c_overrun:  cover property (@(posedge core_clk) $rose(st_q.ovr));
  c_lowpulse: cover property (@(posedge core_clk) st_q.low_pulse);
endmodule
`default_nettype wire

// ==== verification/serial_peer.sv ====
// serial peer model: sends frames on the receive line, captures frames off the transmit line
`timescale 1ns/100ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CYC = 16
) (
  // clock
  input  wire logic core_clk,
  // serial lines
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_q[$];
  logic [9:0] frm;
  logic [7:0] v;
  initial rxd = 1'b1;
  // start bit, eight data bits lsb first, stop bit; line idles high after
  task automatic send(input logic [7:0] b);
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      rxd <= frm[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask
  // capture: find start edge, sample each bit mid-cell
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        v[i] = txd;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      got_q.push_back(v);
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_serial_unit.sv ====
// testbench for the serial flag and clock pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module tb_serial_unit;
  import serial_pkg::*;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;
  logic       core_clk = 1'b0;
  logic       srst     = 1'b1;
  bus_req_s   bus      = '0;
  logic [7:0] rdata;
  logic       rxd;
  logic       sck_i    = 1'b1;
  pins_s      pins;
  logic [7:0] d;
  int         err_count = 0;
  int         compares  = 0;
  int         cyc       = 0;
  int         low_cnt   = 0;
  row_s       rows[5];
  serial_unit #(.DIV_W(8)) dut (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .rxd(rxd), .sck_i(sck_i), .pins(pins));
  serial_peer #(.BIT_CYC(16)) peer (.core_clk(core_clk), .txd(pins.txd), .rxd(rxd));
  always #4 core_clk = ~core_clk;
  // clock pin driven low while enabled
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (pins.sck_oe === 1'b1 && pins.sck_o === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1 v = rdata;
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 1000 && peer.got_q.size() < n; i++) @(posedge core_clk);
  endtask
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rows[0] = '{OFS_BAUD, 8'h5a, 8'h5a};
    rows[1] = '{OFS_SYSCTL, 8'h02, 8'h02};
    rows[2] = '{4'hf, 8'hff, 8'h00};
    rows[3] = '{OFS_BAUD, 8'h00, 8'h00};
    rows[4] = '{OFS_SYSCTL, 8'h00, 8'h00};
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    `CHK(pins.txd, 1'b1)
    `CHK(pins.sck_oe, 1'b0)
    rd(OFS_STATUS, d);
    `CHK(d, 8'h84)
    tdone("reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      `CHK(d, rows[i].exp)
    end
    tdone("table");
    // first byte loads at once; second is overwritten by the third
    wr(OFS_CONTROL, 8'h20);
    wr(OFS_TXHOLD, 8'ha5);
    wr(OFS_TXHOLD, 8'h11);
    wr(OFS_TXHOLD, 8'h77);
    rd(OFS_STATUS, d);
    `CHK(d[ST_TXE_BIT], 1'b0)
    wait_bytes(2);
    `CHK(peer.got_q.size(), 2)
    `CHK(peer.got_q[0], 8'ha5)
    `CHK(peer.got_q[1], 8'h77)
    repeat (40) @(posedge core_clk);
    rd(OFS_STATUS, d);
    `CHK(d[ST_TXE_BIT], 1'b1)
    `CHK(d[ST_TXD_BIT], 1'b1)
    tdone("transmit");
    // subclock mode without division select holds the unit still
    wr(OFS_SYSCTL, 8'h01);
    wr(OFS_TXHOLD, 8'h5a);
    repeat (400) @(posedge core_clk);
    `CHK(peer.got_q.size(), 2)
    wr(OFS_SYSCTL, 8'h03);
    wait_bytes(3);
    `CHK(peer.got_q[2], 8'h5a)
    repeat (20) @(posedge core_clk);
    wr(OFS_SYSCTL, 8'h00);
    tdone("subclock");
    wr(OFS_CONTROL, 8'h30);
    peer.send(8'h3c);
    repeat (20) @(posedge core_clk);
    rd(OFS_STATUS, d);
    `CHK(d[ST_RXF_BIT], 1'b1)
    `CHK(d[ST_OVR_BIT], 1'b0)
    rd(OFS_RXHOLD, d);
    `CHK(d, 8'h3c)
    rd(OFS_STATUS, d);
    `CHK(d[ST_RXF_BIT], 1'b0)
    peer.send(8'h81);
    peer.send(8'h42);
    repeat (20) @(posedge core_clk);
    rd(OFS_STATUS, d);
    `CHK(d[ST_OVR_BIT], 1'b1)
    rd(OFS_RXHOLD, d);
    `CHK(d, 8'h81)
    // read landing on frame completion returns the new frame, flag stays set
    fork
      peer.send(8'h5e);
      begin
        repeat (152) @(posedge core_clk);
        rd(OFS_RXHOLD, d);
      end
    join
    `CHK(d, 8'h5e)
    rd(OFS_STATUS, d);
    `CHK(d[ST_RXF_BIT], 1'b1)
    rd(OFS_RXHOLD, d);
    `CHK(d, 8'h5e)
    // synchronous transmit held off while overrun stands
    wr(OFS_CONTROL, 8'h20);
    wr(OFS_MODE, 8'h80);
    wr(OFS_TXHOLD, 8'hff);
    repeat (20) @(posedge core_clk);
    rd(OFS_STATUS, d);
    `CHK(d[ST_TXE_BIT], 1'b0)
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, d);
    `CHK(d[ST_OVR_BIT], 1'b0)
    `CHK(d[ST_TXE_BIT], 1'b1)
    tdone("receive");
    // clock output handed off directly gives one low pulse
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_MODE, 8'h80);
    repeat (4) @(posedge core_clk);
    `CHK(pins.sck_oe, 1'b1)
    low_cnt <= 0;
    wr(OFS_MODE, 8'h00);
    repeat (6) @(posedge core_clk);
    `CHK(low_cnt, LOWPULSE_CYC)
    // safe sequence leaves no pulse
    wr(OFS_MODE, 8'h80);
    repeat (4) @(posedge core_clk);
    low_cnt <= 0;
    wr(OFS_CONTROL, 8'h02);
    wr(OFS_MODE, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    repeat (6) @(posedge core_clk);
    `CHK(low_cnt, 0)
    `CHK(pins.sck_oe, 1'b0)
    tdone("clock pin");
    // reset in mid-run restores register defaults and idle pins
    wr(OFS_BAUD, 8'h33);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(OFS_BAUD, d);
    `CHK(d, BAUD_RST)
    rd(OFS_STATUS, d);
    `CHK(d, 8'h84)
    `CHK(pins.txd, 1'b1)
    `CHK(pins.sck_oe, 1'b0)
    tdone("reset again");
    stop_test();
  end
endmodule
`default_nettype wire
